/* hdl/qdac_pkg.sv */
// Purpose: shared constants and types of the quad converter serial load front end
// Assumes: 24-bit frames, four channels of 14-bit codes, registers on APB
// Notes: all offsets, field positions and reset values live here
package qdac_pkg;

  ////////////////////////////////////////////////////////////////////////
  // frame layout
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_LEN = 5'h18;
  localparam int ACCEPT_POS = 23;
  localparam int CH_MSB = 22;
  localparam int CH_LSB = 21;
  localparam int PA_MSB = 20;
  localparam int PA_LSB = 16;
  localparam int CODE_W = 14;
  localparam int CH_W = 2;
  localparam int NUM_CH = 4;
  localparam int PA_W = 5;

  ////////////////////////////////////////////////////////////////////////
  // queued update entry: direct flag, channel, code
  localparam int ENT_W = 17;
  localparam int ENT_DIRECT = 16;
  localparam int ENT_CH_MSB = 15;
  localparam int ENT_CH_LSB = 14;
  localparam int FIFO_DEPTH_DEF = 8;

  ////////////////////////////////////////////////////////////////////////
  // pin bundle positions and idle levels
  localparam int PIN_SCLK = 0;
  localparam int PIN_DIN = 1;
  localparam int PIN_FRAME_SYNC_N = 2;
  localparam int PIN_LOAD = 3;
  localparam int PIN_CLEAR = 4;
  localparam int PIN_PA_LSB = 5;
  localparam int PIN_PA_MSB = 9;
  localparam int PIN_W = 10;
  localparam logic [PIN_W-1:0] PIN_IDLE = 10'h01C;

  ////////////////////////////////////////////////////////////////////////
  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] FRAMES_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] INREG_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] LATCH_BASE = 8'h20;
  localparam int CTRL_RISE_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam int ST_CLEAR_BIT = 0;
  localparam int ST_FULL_BIT = 1;
  localparam int ST_EMPTY_BIT = 2;
  localparam int ST_OVF_BIT = 3;
  localparam int ST_SHORT_BIT = 4;
  localparam int ST_IGN_BIT = 5;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic CLEAR_HOLD_RST = 1'b1;

  typedef enum logic [1:0] {LINK_IDLE, LINK_SHIFT, LINK_DONE} qdac_link_state_t;

endpackage : qdac_pkg

/* hdl/qdac_sync.sv */
// Purpose: three-flop pin synchroniser with agreement filter and edge pulses
// Assumes: inputs are asynchronous to pclk
// Notes: a change counts once the second and third flops agree
`timescale 1ns/1ps
module qdac_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins
  input wire logic [WIDTH-1:0] pin_in,
  // filtered level and edges
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg;
  logic [WIDTH-1:0] level_next;

  // first flop feeds only the second
  assign level_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & level);

  // chain, filter and edge pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      level <= RST_VAL;
      rise <= '0;
      fall <= '0;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level <= level_next;
      rise <= level_next & ~level;
      fall <= ~level_next & level;
    end
  end

endmodule : qdac_sync

/* hdl/qdac_fifo.sv */
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: single clock
// Notes: in_ready is low exactly when full
`timescale 1ns/1ps
module qdac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_BITS = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_BITS-1:0] FULL_CNT = CNT_BITS'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_reg, rd_reg;
  logic [CNT_BITS-1:0] cnt_reg;
  logic push, pop;

  // handshakes
  assign in_ready = (cnt_reg != FULL_CNT);
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage writes, no reset needed on data
  always_ff @(posedge pclk)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end

  // pointers and fill level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
      if (push != pop)
        cnt_reg <= push ? cnt_reg + 1'b1 : cnt_reg - 1'b1;
    end
  end

endmodule : qdac_fifo

/* hdl/qdac_serial_load.sv */
// Purpose: serial load front end of a quad 14-bit converter, with APB status
// Assumes: pclk 10 MHz, link pins asynchronous, serial clock at most pclk/8
// Notes: decoded frames queue in a FIFO before they touch the input registers
//
// What this block does
// RQ1 - latch codes are plain straight binary, zero low, all ones top minus one step
// RQ2 - each output follows its own latch; host data enters one input register
// RQ3 - clear low forces sense ground; held there until load is exercised
// RQ4 - a frame is 24 bits: 8 control bits then 16 data bits
// RQ5 - load high leaves outputs alone; load low copies all input registers
// RQ6 - with load low, frame end writes straight into the addressed latch
// RQ7 - bits shift into 24-bit register; only the last 24 count
// RQ8 - first bit set accepts the frame; clear means ignore the rest
// RQ9 - two channel bits pick channel one to four in binary order
// RQ10 - five address bits must match the package address pins
// RQ11 - host puts two zeros then the 14-bit code, msb first
// RQ12 - while clear is low, load is ignored and outputs stay at sense ground
// RQ13 - data sampled on one serial clock edge; frame end writes input register
// RQ14 - mismatched or unselected frames change no register or latch
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module qdac_serial_load
  import qdac_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link pins
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic frame_sync_n,
  input wire logic dac_load_n,
  input wire logic output_clear_n,
  input wire logic [PA_W-1:0] package_addr_pins,
  // converter side
  output logic [NUM_CH-1:0][CODE_W-1:0] dac_latch_code,
  output logic sense_ground_level
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // sticky flag: a set in the clearing cycle wins
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction : sticky

  // word-aligned hit inside a bank of four registers
  function automatic logic in_bank(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    return (a[ADDR_W-1:4] == b[ADDR_W-1:4]) && (a[1:0] == 2'b00);
  endfunction : in_bank

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  logic [PIN_W-1:0] pin_raw, pin_lvl, pin_rise, pin_fall;

  assign pin_raw = {package_addr_pins, output_clear_n, dac_load_n,
                    frame_sync_n, serial_data_in, serial_clock};

  qdac_sync #(
    .WIDTH(PIN_W),
    .RST_VAL(PIN_IDLE)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(pin_raw),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // state

  qdac_link_state_t state_reg, state_next;
  logic [FRAME_BITS-1:0] shift_reg, shift_next;
  logic [CNT_W-1:0] bits_reg, bits_next;
  logic [1:0] ctrl_reg;
  logic ovf_reg, short_reg, ign_reg;
  logic [15:0] frames_reg;
  logic clear_hold_reg, clear_hold_next;
  logic [NUM_CH-1:0][CODE_W-1:0] inreg_reg, inreg_next;
  logic [NUM_CH-1:0][CODE_W-1:0] latch_reg, latch_next;
  logic [31:0] rdata_next;
  logic err_next;

  ////////////////////////////////////////////////////////////////////////
  // link decode

  logic sample_edge, load_low, clear_low, din_lvl;
  logic full_frame, accept, addr_match, good_frame, at_done;
  logic push_valid, push_ready, push_ok;
  logic [ENT_W-1:0] push_data;

  // one fixed serial clock edge, chosen by software
  assign sample_edge = ctrl_reg[CTRL_RISE_BIT] ? pin_rise[PIN_SCLK] : pin_fall[PIN_SCLK]; // [RQ13]
  assign din_lvl = pin_lvl[PIN_DIN];
  assign load_low = ~pin_lvl[PIN_LOAD];
  assign clear_low = ~pin_lvl[PIN_CLEAR];

  // frame evaluation in the cycle after frame sync rises
  assign at_done = (state_reg == LINK_DONE);
  assign full_frame = (bits_reg == FRAME_LEN); // [RQ4]
  assign accept = shift_reg[ACCEPT_POS]; // [RQ8]
  assign addr_match = (shift_reg[PA_MSB:PA_LSB] == pin_lvl[PIN_PA_MSB:PIN_PA_LSB]); // [RQ10]
  assign good_frame = full_frame & accept & addr_match; // [RQ14]
  assign push_valid = at_done & good_frame;
  assign push_ok = push_valid & push_ready;

  // the top two data bits are padding; only the 14-bit code is queued
  assign push_data = {load_low, shift_reg[CH_MSB:CH_LSB], shift_reg[CODE_W-1:0]}; // [RQ11]

  // frame state machine
  always_comb
  begin
    state_next = state_reg;
    shift_next = shift_reg;
    bits_next = bits_reg;
    unique case (state_reg)
      LINK_IDLE:
      begin
        if (pin_fall[PIN_FRAME_SYNC_N])
        begin
          bits_next = '0;
          state_next = LINK_SHIFT;
        end
      end
      LINK_SHIFT:
      begin
        // older bits fall off the top, so the last 24 remain
        if (sample_edge)
        begin
          shift_next = {shift_reg[FRAME_BITS-2:0], din_lvl}; // [RQ7]
          if (bits_reg != FRAME_LEN)
            bits_next = bits_reg + 1'b1;
        end
        if (pin_rise[PIN_FRAME_SYNC_N])
          state_next = LINK_DONE;
      end
      LINK_DONE:
      begin
        state_next = LINK_IDLE;
      end
      default:
      begin
        state_next = LINK_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // update queue

  logic ent_valid, ent_ready, apply, ent_direct;
  logic [ENT_W-1:0] ent_data;
  logic [CH_W-1:0] ent_ch;
  logic [CODE_W-1:0] ent_code;

  // software can stall the drain; the queue then fills and frames drop
  assign ent_ready = ~ctrl_reg[CTRL_HOLD_BIT];
  assign apply = ent_valid & ent_ready;
  assign ent_direct = ent_data[ENT_DIRECT];
  assign ent_ch = ent_data[ENT_CH_MSB:ENT_CH_LSB];
  assign ent_code = ent_data[CODE_W-1:0];

  qdac_fifo #(
    .WIDTH(ENT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(ent_valid),
    .out_ready(ent_ready),
    .out_data(ent_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // input registers and converter latches

  // per channel: input register on every applied entry, latch per load mode
  always_comb
  begin
    inreg_next = inreg_reg;
    latch_next = latch_reg;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (apply && (ent_ch == CH_W'(i))) // [RQ9]
        inreg_next[i] = ent_code; // [RQ2] [RQ13]
      if (!clear_low) // [RQ12]
      begin
        if (apply && ent_direct && (ent_ch == CH_W'(i)))
          latch_next[i] = ent_code; // [RQ6]
        else if (load_low)
          latch_next[i] = inreg_reg[i]; // [RQ5]
      end
    end
  end

  // outputs stay parked until load is seen with clear released
  assign clear_hold_next = clear_low ? 1'b1 : (load_low ? 1'b0 : clear_hold_reg); // [RQ3]

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  logic access, commit, wr_fire;
  logic hit_ctrl, hit_status, hit_frames, hit_inreg, hit_latch, mapped;
  logic [CH_W-1:0] bank_idx;
  logic [5:0] status_word;

  // first access cycle loads the answer, second one completes
  assign access = psel & penable & ~pready;
  assign commit = psel & penable & pready;
  assign wr_fire = commit & pwrite & pstrb[0];
  assign hit_ctrl = (paddr == CTRL_OFS);
  assign hit_status = (paddr == STATUS_OFS);
  assign hit_frames = (paddr == FRAMES_OFS);
  assign hit_inreg = in_bank(paddr, INREG_BASE);
  assign hit_latch = in_bank(paddr, LATCH_BASE);
  assign mapped = hit_ctrl | hit_status | hit_frames | hit_inreg | hit_latch;
  assign bank_idx = paddr[3:2];
  assign status_word = {ign_reg, short_reg, ovf_reg, ~ent_valid, ~push_ready, clear_hold_reg};

  // read data mux, unmapped reads give zero and an error
  always_comb
  begin
    rdata_next = '0;
    err_next = ~mapped;
    if (hit_ctrl)
      rdata_next[1:0] = ctrl_reg;
    if (hit_status)
      rdata_next[5:0] = status_word;
    if (hit_frames)
      rdata_next[15:0] = frames_reg;
    if (hit_inreg)
      rdata_next[CODE_W-1:0] = inreg_reg[bank_idx];
    if (hit_latch)
      rdata_next[CODE_W-1:0] = latch_reg[bank_idx]; // [RQ1]
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  // link side flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= LINK_IDLE;
      shift_reg <= '0;
      bits_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bits_reg <= bits_next;
    end
  end

  // channel storage; reset lands at code zero with outputs parked
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      inreg_reg <= '0;
      latch_reg <= '0;
      clear_hold_reg <= CLEAR_HOLD_RST;
    end
    else
    begin
      inreg_reg <= inreg_next;
      latch_reg <= latch_next;
      clear_hold_reg <= clear_hold_next;
    end
  end

  // control and sticky status; status bits clear on a written one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= CTRL_RST;
      ovf_reg <= 1'b0;
      short_reg <= 1'b0;
      ign_reg <= 1'b0;
      frames_reg <= '0;
    end
    else
    begin
      if (wr_fire && hit_ctrl)
        ctrl_reg <= pwdata[1:0];
      ovf_reg <= sticky(ovf_reg, push_valid & ~push_ready,
                        wr_fire & hit_status & pwdata[ST_OVF_BIT]);
      short_reg <= sticky(short_reg, at_done & ~full_frame,
                          wr_fire & hit_status & pwdata[ST_SHORT_BIT]);
      ign_reg <= sticky(ign_reg, at_done & full_frame & ~good_frame, // [RQ14]
                        wr_fire & hit_status & pwdata[ST_IGN_BIT]);
      if (push_ok)
        frames_reg <= frames_reg + 1'b1;
    end
  end

  // bus answer flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= access;
      pslverr <= access & err_next; // only stands with ready
      if (access)
      begin
        prdata <= rdata_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // converter outputs straight from flops

  assign dac_latch_code = latch_reg; // [RQ1] [RQ2]
  assign sense_ground_level = clear_hold_reg; // [RQ3]

endmodule : qdac_serial_load

/* test/qdac_link_host.sv */
// Purpose: host side of the serial load link, sends frames on request
// Assumes: device samples on the falling edge unless sample_rise is set, 800 ns period
// Notes: clock stands high between frames; data shows the inverse of its last bit
`timescale 1ns/1ps
module qdac_link_host
(
  // link pins
  output logic serial_clock,
  output logic serial_data_in,
  output logic frame_sync_n
);
  // set by the bench when the device samples on the rising edge
  logic sample_rise;

  // idle link at time zero
  initial
  begin
    serial_clock = 1'b1;
    serial_data_in = 1'b0;
    frame_sync_n = 1'b1;
    sample_rise = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // msb first; odd offset keeps edges off the bus clock phase
  task automatic send(input logic [31:0] word, input int nbits);
    #37;
    frame_sync_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      if (!sample_rise)
        serial_data_in = word[i];
      #400 serial_clock = 1'b0;
      // rising-edge mode: data moves on the fall, stable across the rise
      if (sample_rise)
        serial_data_in = word[i];
      #400 serial_clock = 1'b1;
    end
    #400 frame_sync_n = 1'b1;
    // released line must not keep looking valid
    serial_data_in = ~serial_data_in;
    #1200;
  endtask : send
endmodule : qdac_link_host

/* test/qdac_serial_load_properties.sv */
// Purpose: port-level properties of the serial load front end
// Assumes: pins pass a short synchroniser, about four pclk of delay
// Notes: windows are kept a little wider than the synchroniser delay
`timescale 1ns/1ps
module qdac_serial_load_properties
  import qdac_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // pins and outputs
  input wire logic dac_load_n,
  input wire logic output_clear_n,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] dac_latch_code,
  input wire logic sense_ground_level
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////
  property p_clear_forces;
    $fell(output_clear_n) |-> ##[1:8] sense_ground_level;
  endproperty
  a_clear_forces: assert property (p_clear_forces)
    else $error("outputs not at sense ground after clear");
  property p_clear_freezes;
    (!output_clear_n) [*8] |=> $stable(dac_latch_code);
  endproperty
  a_clear_freezes: assert property (p_clear_freezes)
    else $error("latch moved while clear low");
  property p_sense_hold;
    (dac_load_n [*8]) ##0 sense_ground_level |=> sense_ground_level;
  endproperty
  a_sense_hold: assert property (p_sense_hold)
    else $error("sense ground left without load");
  property p_sense_release;
    (output_clear_n && !dac_load_n) [*8] |-> !sense_ground_level;
  endproperty
  a_sense_release: assert property (p_sense_release)
    else $error("sense ground kept after load");
  property p_load_high_stable;
    (dac_load_n && output_clear_n) [*8] |=> $stable(dac_latch_code);
  endproperty
  a_load_high_stable: assert property (p_load_high_stable)
    else $error("latch moved with load high");
  // one wait state, then a single-cycle answer
  property p_apb_wait;
    psel && $rose(penable) |-> !pready ##1 pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("answer not in second access cycle");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("ready longer than one cycle");
  property p_err_clean;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  a_err_clean: assert property (p_err_clean)
    else $error("error without ready or with data");
endmodule : qdac_serial_load_properties

/* test/qdac_serial_load_tb_top.sv */
// Purpose: self-checking bench of the serial load front end
// Assumes: falling-edge sampling until the last frame, which uses the rising edge; package address pins tied
// Notes: expected latches tracked in exp_l
`timescale 1ns/1ps
module qdac_serial_load_tb_top
  import qdac_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, n0;
  logic [3:0] pstrb;
  logic serial_clock, serial_data_in, frame_sync_n, dac_load_n, output_clear_n;
  logic [PA_W-1:0] package_addr_pins;
  logic [NUM_CH-1:0][CODE_W-1:0] dac_latch_code, exp_l;
  logic sense_ground_level;
  logic [CODE_W-1:0] codes [4] = '{14'h3fff, 14'h0001, 14'h2000, 14'h1fff};
  localparam logic [PA_W-1:0] PA = 5'h15;
  int n_errors, checks;

  ////////////////////////////////////////////////////////////////////////
  qdac_serial_load i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .frame_sync_n(frame_sync_n), .dac_load_n(dac_load_n),
    .output_clear_n(output_clear_n), .package_addr_pins(package_addr_pins),
    .dac_latch_code(dac_latch_code), .sense_ground_level(sense_ground_level));
  qdac_link_host i_host (.serial_clock(serial_clock), .serial_data_in(serial_data_in),
    .frame_sync_n(frame_sync_n));

  // 10 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // holds the request until ready is seen at an edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      n_errors++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(64'(rd), 64'(exp));
  endtask : rdchk
  task automatic frame(input logic acc, input logic [1:0] ch, input logic [4:0] pa,
                       input logic [13:0] code);
    i_host.send({8'h00, acc, ch, pa, 2'b00, code}, 24);
    @(posedge pclk);
  endtask : frame
  // load low long enough to pass the synchroniser
  task automatic pulse();
    dac_load_n <= 1'b0;
    repeat (10) @(posedge pclk);
    dac_load_n <= 1'b1;
    repeat (10) @(posedge pclk);
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_errors = 0;
    checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    dac_load_n = 1'b1;
    output_clear_n = 1'b1;
    package_addr_pins = PA;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rdchk(STATUS_OFS, 32'h0000_0005);
    rdchk(8'h40, 32'h0000_0000);
    chk(64'(err), 64'h1);
    // one input register per frame, outputs untouched
    for (int c = 0; c < 4; c++)
      frame(1'b1, c[1:0], PA, codes[c]);
    for (int c = 0; c < 4; c++)
      rdchk(INREG_BASE + 8'(4 * c), 32'(codes[c]));
    chk(64'(dac_latch_code), 64'h0);
    pulse();
    exp_l = {codes[3], codes[2], codes[1], codes[0]};
    chk(64'(dac_latch_code), 64'(exp_l));
    chk(64'(sense_ground_level), 64'h0);
    // unselected and foreign frames
    frame(1'b0, 2'd1, PA, 14'h0aaa);
    frame(1'b1, 2'd1, PA ^ 5'h01, 14'h0aaa);
    rdchk(INREG_BASE + 8'h04, 32'(codes[1]));
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(64'(rd[ST_IGN_BIT]), 64'h1);
    apb(1'b1, STATUS_OFS, 32'h0000_0020);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(64'(rd[ST_IGN_BIT]), 64'h0);
    // overlong frame keeps the last 24 bits, short one is dropped
    i_host.send({6'h00, 2'b10, 1'b1, 2'd2, PA, 2'b00, 14'h1234}, 26);
    i_host.send({8'h00, 1'b1, 2'd2, PA, 2'b00, 14'h0f0f}, 20);
    rdchk(INREG_BASE + 8'h08, 32'h0000_1234);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(64'(rd[ST_SHORT_BIT]), 64'h1);
    // load held low: frame end goes straight to the latch
    dac_load_n <= 1'b0;
    frame(1'b1, 2'd3, PA, 14'h2aaa);
    exp_l[2] = 14'h1234;
    exp_l[3] = 14'h2aaa;
    chk(64'(dac_latch_code), 64'(exp_l));
    // clear low overrides load; level kept after release
    dac_load_n <= 1'b1;
    repeat (10) @(posedge pclk);
    output_clear_n <= 1'b0;
    repeat (10) @(posedge pclk);
    frame(1'b1, 2'd0, PA, 14'h0555);
    pulse();
    chk(64'(sense_ground_level), 64'h1);
    chk(64'(dac_latch_code), 64'(exp_l));
    output_clear_n <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(64'(sense_ground_level), 64'h1);
    pulse();
    exp_l[0] = 14'h0555;
    chk(64'(sense_ground_level), 64'h0);
    chk(64'(dac_latch_code), 64'(exp_l));
    // queue held: nine frames overflow an eight-deep queue
    apb(1'b1, CTRL_OFS, 32'h0000_0002);
    rdchk(CTRL_OFS, 32'h0000_0002);
    apb(1'b0, FRAMES_OFS, 32'h0000_0000);
    n0 = rd;
    for (int i = 0; i < 9; i++)
      frame(1'b1, 2'd1, PA, 14'(i + 1));
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(64'({rd[ST_OVF_BIT], rd[ST_FULL_BIT]}), 64'h3);
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    apb(1'b1, FRAMES_OFS, 32'h0000_0000);
    rdchk(FRAMES_OFS, 32'((n0 + 8) & 32'h0000_ffff));
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(64'(rd[ST_EMPTY_BIT]), 64'h1);
    rdchk(INREG_BASE + 8'h04, 32'h0000_0008);
    chk(64'(dac_latch_code), 64'(exp_l));
    // rising serial clock edge chosen for sampling
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    i_host.sample_rise = 1'b1;
    frame(1'b1, 2'd1, PA, 14'h1555);
    rdchk(INREG_BASE + 8'h04, 32'h0000_1555);
    chk(64'(dac_latch_code), 64'(exp_l));
    results();
  end
endmodule : qdac_serial_load_tb_top

bind qdac_serial_load qdac_serial_load_properties i_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .dac_load_n(dac_load_n), .output_clear_n(output_clear_n),
  .dac_latch_code(dac_latch_code), .sense_ground_level(sense_ground_level));
